// >>> logic/pcsd_pkg.sv
// Constants, code-group tables and carrier types for the 100BASE-X codec.
// Assumes a 125 MHz recovered link clock and a 100 MHz system clock.
// How it works
// - Transmit error in frame sends halt groups
// - Delimiters stay intact around errored frames
// - Received NRZI is converted to NRZ
// - Receive logic runs on recovered clock
// - Bypass NRZI, descrambler, alignment, decoder separately
// - Descrambler works five bits per group
// - Sixteen descrambled idles achieve synchronization
// - Synchronization starts the hold timer
// - Enough idles reload the hold timer
// - Timer expiry drops synchronization
// - Sixteen data nibbles map to data groups
// - Idle group reads as nibble zero
// - Start delimiter groups read as 0101
// - End delimiter groups read as 0000
// - Halt group signals an error
// - Control groups inside data are invalid
// - Invalid groups give nibble 6 with error
// - Invalid select gives nibble 5 instead
// - Encoder sends J/K, data, T/R, idles
// - Decoder outputs 0101 pair, stops on T/idles
// - Long timeout option and timer disable
// - Scrambling sequence from 11-bit LFSR
`default_nettype none
package pcsd_pkg;
  // Control code-groups, most significant bit sent first.
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;
  // Nibbles presented on the receive side.
  localparam logic [3:0] NIB_SSD = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_INV = 4'h6;
  localparam logic [3:0] NIB_INV_ALT = 4'h5;
  // Data code-groups indexed by nibble value.
  localparam logic [4:0] DATA_CG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  // Descrambler sequence generator.
  localparam int LFSR_W = 11;
  localparam int TAP_HI = 10;
  localparam int TAP_LO = 8;
  localparam logic [10:0] LFSR_RST = 11'h7FF;
  // Group framing and synchronization thresholds.
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam logic [4:0] IDLE_LOCK = 5'h10;
  localparam logic [4:0] IDLE_HOLD = 5'h02;
  // Hold timer figures in microseconds and their link-clock counts.
  localparam int LINK_MHZ = 125;
  localparam int HOLD_US = 722;
  localparam int LONG_US = 2000;
  localparam int HOLD_CYC = HOLD_US * LINK_MHZ;
  localparam int LONG_CYC = LONG_US * LINK_MHZ;
  localparam int TMR_W = 18;
  localparam logic [17:0] TMR_ONE = 18'h00001;
  // Configuration carried from the system domain.
  typedef struct packed {
    logic byp_nrzi;   // Pass line bits without NRZI decoding.
    logic byp_descr;  // Pass groups without descrambling.
    logic byp_align;  // Take groups at a fixed boundary.
    logic byp_dec;    // Present raw 5-bit groups.
    logic inv_sel;    // Invalid groups read as 5h instead of 6h.
    logic long_hold;  // Use the long hold timeout.
    logic hold_dis;   // Never time out synchronization.
  } pcsd_cfg_t;
  // Receive nibble interface.
  typedef struct packed {
    logic dv;         // Frame data valid.
    logic er;         // Receive error, or group bit 4 when decoding is bypassed.
    logic [3:0] rxd;  // Receive nibble.
  } pcsd_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} pcsd_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_K, RX_DATA} pcsd_rx_st_t;
endpackage : pcsd_pkg
`default_nettype wire

// >>> logic/pcsd_descr5.sv
// Five-bit parallel descrambler with its sequence generator.
// Assumes i_sd holds one group, first received bit in bit 4.
`default_nettype none
module pcsd_descr5 (
  input wire logic i_clk,        // Recovered link clock.
  input wire logic i_rst_n,      // Synchronous reset, active low.
  input wire logic i_stb,        // Group strobe.
  input wire logic i_hunt,       // Not synchronized: learn the sequence.
  input wire logic [4:0] i_sd,   // Scrambled group.
  output logic [4:0] o_ud        // Descrambled group.
);
  logic [10:0] lfsr_reg;  // Sequence generator state.
  logic [10:0] lfsr_next; // State after one group.

  // Step the generator over five bits and strip the sequence from the data.
  always_comb begin
    logic kbit;
    logic fb;
    kbit = 1'b0;
    fb = 1'b0;
    lfsr_next = lfsr_reg;
    o_ud = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      kbit = lfsr_next[pcsd_pkg::TAP_HI] ^ lfsr_next[pcsd_pkg::TAP_LO];
      o_ud[i] = i_sd[i] ^ kbit;
      // While hunting, assume idle so the line reveals the sequence bit.
      fb = i_hunt ? ~i_sd[i] : kbit;
      lfsr_next = {lfsr_next[9:0], fb};
    end
  end

  // Advance once per group.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lfsr_reg <= pcsd_pkg::LFSR_RST;
    end else if (i_stb) begin
      lfsr_reg <= lfsr_next;
    end
  end
endmodule : pcsd_descr5
`default_nettype wire

// >>> logic/pcsd_top.sv
// 100BASE-X coding path: 4B/5B transmit encoder and full receive chain.
// Assumes the transmit nibbles arrive one per system clock and the line
// delivers one NRZI bit per recovered clock edge.
`default_nettype none
module pcsd_top #(
  parameter int HOLD_CYCLES = pcsd_pkg::HOLD_CYC, // Short hold timeout in link cycles.
  parameter int LONG_CYCLES = pcsd_pkg::LONG_CYC  // Long hold timeout in link cycles.
) (
  input wire logic i_clk_sys,             // System clock, transmit side.
  input wire logic i_rst_n,               // Synchronous reset, active low.
  input wire logic i_clk_rec,             // Recovered 125 MHz link clock.
  input wire pcsd_pkg::pcsd_cfg_t i_cfg,  // Configuration, system domain.
  input wire logic i_tx_en,               // Transmit enable.
  input wire logic i_tx_er,               // Transmit error.
  input wire logic [3:0] i_txd,           // Transmit nibble.
  input wire logic i_rx_bit,              // Serial line bit, recovered domain.
  output logic [4:0] o_tx_group,          // Code-group to the line.
  output pcsd_pkg::pcsd_rx_t o_rx,        // Receive nibble interface.
  output logic o_rx_stb,                  // One-cycle pulse per receive nibble.
  output logic o_sync                     // Descrambler synchronized.
);
  // ---------------- Transmit encoder, system domain ----------------
  pcsd_pkg::pcsd_tx_st_t tx_st_reg; // Encoder state.

  // Frame the nibbles with J/K and T/R, substituting halt on errors.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tx_st_reg <= pcsd_pkg::TX_IDLE;
      o_tx_group <= pcsd_pkg::CG_IDLE;
    end else begin
      case (tx_st_reg)
        pcsd_pkg::TX_IDLE: begin
          if (i_tx_en) begin
            // First preamble nibble becomes J.
            o_tx_group <= pcsd_pkg::CG_J;
            tx_st_reg <= pcsd_pkg::TX_K;
          end else begin
            o_tx_group <= pcsd_pkg::CG_IDLE;
          end
        end
        pcsd_pkg::TX_K: begin
          // Second preamble nibble becomes K, even when errored.
          o_tx_group <= pcsd_pkg::CG_K;
          tx_st_reg <= pcsd_pkg::TX_DATA;
        end
        pcsd_pkg::TX_DATA: begin
          if (!i_tx_en) begin
            o_tx_group <= pcsd_pkg::CG_T;
            tx_st_reg <= pcsd_pkg::TX_R;
          end else if (i_tx_er) begin
            o_tx_group <= pcsd_pkg::CG_HALT;
          end else begin
            o_tx_group <= pcsd_pkg::DATA_CG[i_txd];
          end
        end
        default: begin
          o_tx_group <= pcsd_pkg::CG_R;
          tx_st_reg <= pcsd_pkg::TX_IDLE;
        end
      endcase
    end
  end

  a_tx_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tx_st_reg == pcsd_pkg::TX_DATA && i_tx_en && i_tx_er |=> o_tx_group == pcsd_pkg::CG_HALT)
    else $error("halt not sent for errored nibble");
  a_tx_ssd_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tx_st_reg == pcsd_pkg::TX_IDLE && i_tx_en
    |=> o_tx_group == pcsd_pkg::CG_J ##1 o_tx_group == pcsd_pkg::CG_K)
    else $error("start delimiter pair missing");
  a_tx_esd_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tx_st_reg == pcsd_pkg::TX_DATA && !i_tx_en
    |=> o_tx_group == pcsd_pkg::CG_T ##1 o_tx_group == pcsd_pkg::CG_R)
    else $error("end delimiter pair missing");
  a_tx_data_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tx_st_reg == pcsd_pkg::TX_DATA && i_tx_en && !i_tx_er
    |=> o_tx_group == pcsd_pkg::DATA_CG[$past(i_txd)])
    else $error("data nibble encoded wrongly");

  // ---------------- Crossing into the recovered domain ----------------
  logic [7:0] cx_s1; // First stage, read only by the second.
  logic [7:0] cx_s2; // Second stage.
  logic [7:0] cx_s3; // Third stage.
  logic [7:0] cx_acc; // Accepted value: bit follows once stages two and three agree.
  logic rec_rst_n; // Reset in the recovered domain.
  pcsd_pkg::pcsd_cfg_t cfg; // Configuration in the recovered domain.

  // Reset and configuration are levels, so a three-stage synchroniser suffices.
  always_ff @(posedge i_clk_rec) begin
    cx_s1 <= {i_rst_n, i_cfg};
    cx_s2 <= cx_s1;
    cx_s3 <= cx_s2;
    cx_acc <= (cx_s2 & cx_s3) | (cx_acc & (cx_s2 ^ cx_s3));
  end
  assign rec_rst_n = cx_acc[7];
  assign cfg = pcsd_pkg::pcsd_cfg_t'(cx_acc[6:0]);

  // ---------------- NRZI decode and group framing ----------------
  logic line_prev_reg; // Previous line bit.
  logic nrz_bit;       // Decoded bit.
  logic [3:0] sh_reg;  // Bits of the group being gathered.
  logic [2:0] bcnt_reg; // Bit position within the group.
  logic [4:0] grp_reg; // Complete unaligned group.
  logic grp_stb_reg;   // Group ready this cycle.

  // A transition means one; bypass passes the line bit straight.
  assign nrz_bit = cfg.byp_nrzi ? i_rx_bit : (i_rx_bit ^ line_prev_reg);

  // Every receive register runs on the recovered clock.
  always_ff @(posedge i_clk_rec) begin
    if (!rec_rst_n) begin
      line_prev_reg <= 1'b0;
      sh_reg <= 4'h0;
      bcnt_reg <= 3'h0;
      grp_reg <= 5'h00;
      grp_stb_reg <= 1'b0;
    end else begin
      line_prev_reg <= i_rx_bit;
      sh_reg <= {sh_reg[2:0], nrz_bit};
      grp_stb_reg <= (bcnt_reg == pcsd_pkg::GRP_LAST);
      if (bcnt_reg == pcsd_pkg::GRP_LAST) begin
        grp_reg <= {sh_reg, nrz_bit};
        bcnt_reg <= 3'h0;
      end else begin
        bcnt_reg <= bcnt_reg + 3'h1;
      end
    end
  end

  // ---------------- Descrambler and synchronization ----------------
  localparam int TMR_W = pcsd_pkg::TMR_W; // Hold timer width, needed by the reload cast below.
  logic lock_reg;        // Descrambler synchronized.
  logic [4:0] run_reg;   // Consecutive descrambled idles, saturating.
  logic [17:0] tmr_reg;  // Hold timer countdown.
  logic [4:0] dsc_ud;    // Descrambler output.
  logic [4:0] ud;        // Group after the descrambler or its bypass.
  logic ud_idle;         // Current group is idle.
  logic reload;          // Enough idles seen to refresh the timer.
  logic sync_ok;         // Receive data may be presented.
  logic [17:0] tmr_load; // Timer reload value.

  pcsd_descr5 u_descr (
    .i_clk(i_clk_rec),
    .i_rst_n(rec_rst_n),
    .i_stb(grp_stb_reg),
    .i_hunt(!lock_reg),
    .i_sd(grp_reg),
    .o_ud(dsc_ud)
  );

  assign ud = cfg.byp_descr ? grp_reg : dsc_ud;
  assign ud_idle = (ud == pcsd_pkg::CG_IDLE);
  assign reload = grp_stb_reg && ud_idle && (run_reg >= pcsd_pkg::IDLE_HOLD - 5'h01);
  assign sync_ok = cfg.byp_descr || lock_reg;
  assign tmr_load = cfg.long_hold ? TMR_W'(LONG_CYCLES) : TMR_W'(HOLD_CYCLES);

  // Count idles, take lock after sixteen, and police it with the hold timer.
  always_ff @(posedge i_clk_rec) begin
    if (!rec_rst_n) begin
      lock_reg <= 1'b0;
      run_reg <= 5'h00;
      tmr_reg <= 18'h00000;
    end else if (lock_reg && !cfg.hold_dis && tmr_reg == pcsd_pkg::TMR_ONE && !reload) begin
      // Expiry drops lock and restarts the idle hunt.
      lock_reg <= 1'b0;
      run_reg <= 5'h00;
      tmr_reg <= 18'h00000;
    end else begin
      if (grp_stb_reg) begin
        if (!ud_idle) begin
          run_reg <= 5'h00;
        end else if (run_reg != pcsd_pkg::IDLE_LOCK) begin
          run_reg <= run_reg + 5'h01;
        end
      end
      if (!lock_reg) begin
        if (grp_stb_reg && ud_idle && run_reg == pcsd_pkg::IDLE_LOCK - 5'h01) begin
          lock_reg <= 1'b1;
          tmr_reg <= tmr_load;
        end
      end else if (reload) begin
        tmr_reg <= tmr_load;
      end else if (!cfg.hold_dis) begin
        tmr_reg <= tmr_reg - pcsd_pkg::TMR_ONE;
      end
    end
  end

  // ---------------- Code-group alignment ----------------
  logic [14:0] hist_reg;  // Last three groups, newest in the low bits.
  logic hist_stb_reg;     // History updated this cycle.
  logic [4:0] jk_hit;     // J/K pair found at each bit offset.
  logic [2:0] off_reg;    // Locked alignment offset.
  logic [2:0] off_use;    // Offset applied to this group.
  logic [4:0] dgrp;       // Aligned group for the decoder.
  pcsd_pkg::pcsd_rx_st_t rx_st_reg; // Decoder state.

  // Look for the start delimiter pair at every bit offset.
  for (genvar o = 0; o < 5; o++) begin : g_jk
    assign jk_hit[o] = (hist_reg[o+9:o] == {pcsd_pkg::CG_J, pcsd_pkg::CG_K});
  end

  // Realign only between frames; bypass takes offset zero.
  always_comb begin
    off_use = off_reg;
    if (cfg.byp_align) begin
      off_use = 3'h0;
    end else if (rx_st_reg == pcsd_pkg::RX_IDLE) begin
      for (int o = 4; o >= 0; o--) begin
        if (jk_hit[o]) begin
          off_use = 3'(o);
        end
      end
    end
  end
  assign dgrp = hist_reg[{1'b0, off_use} + 4'h5 +: 5];

  // Shift groups into the history and hold the chosen offset.
  always_ff @(posedge i_clk_rec) begin
    if (!rec_rst_n) begin
      hist_reg <= 15'h7FFF;
      hist_stb_reg <= 1'b0;
      off_reg <= 3'h0;
    end else begin
      hist_stb_reg <= grp_stb_reg;
      if (grp_stb_reg) begin
        hist_reg <= {hist_reg[9:0], ud};
      end
      if (hist_stb_reg) begin
        off_reg <= off_use;
      end
    end
  end

  // ---------------- 5B to 4B decoder ----------------
  logic dat_hit;       // Group is one of the sixteen data groups.
  logic [3:0] dat_nib; // Nibble of that data group.
  logic [3:0] inv_nib; // Nibble shown for invalid groups.
  logic prev_idle_reg; // Previous aligned group was idle.

  // Reverse lookup of the data table.
  always_comb begin
    dat_hit = 1'b0;
    dat_nib = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (pcsd_pkg::DATA_CG[i] == dgrp) begin
        dat_hit = 1'b1;
        dat_nib = 4'(i);
      end
    end
  end
  assign inv_nib = cfg.inv_sel ? pcsd_pkg::NIB_INV_ALT : pcsd_pkg::NIB_INV;

  // Translate one aligned group per strobe into the receive interface.
  always_ff @(posedge i_clk_rec) begin
    if (!rec_rst_n) begin
      rx_st_reg <= pcsd_pkg::RX_IDLE;
      o_rx <= '0;
      o_rx_stb <= 1'b0;
      prev_idle_reg <= 1'b0;
    end else begin
      o_rx_stb <= hist_stb_reg;
      if (hist_stb_reg) begin
        prev_idle_reg <= (dgrp == pcsd_pkg::CG_IDLE);
        if (!sync_ok) begin
          // Nothing is presented until synchronization returns.
          o_rx <= '0;
          rx_st_reg <= pcsd_pkg::RX_IDLE;
        end else if (cfg.byp_dec) begin
          // Transparent mode: bit 4 rides on the error line.
          o_rx <= '{dv: 1'b1, er: dgrp[4], rxd: dgrp[3:0]};
        end else begin
          case (rx_st_reg)
            pcsd_pkg::RX_IDLE: begin
              if (dgrp == pcsd_pkg::CG_J) begin
                o_rx <= '{dv: 1'b1, er: 1'b0, rxd: pcsd_pkg::NIB_SSD};
                rx_st_reg <= pcsd_pkg::RX_K;
              end else begin
                o_rx <= '{dv: 1'b0, er: 1'b0, rxd: pcsd_pkg::NIB_ZERO};
              end
            end
            pcsd_pkg::RX_K: begin
              if (dgrp == pcsd_pkg::CG_K) begin
                o_rx <= '{dv: 1'b1, er: 1'b0, rxd: pcsd_pkg::NIB_SSD};
                rx_st_reg <= pcsd_pkg::RX_DATA;
              end else begin
                o_rx <= '{dv: 1'b1, er: 1'b1, rxd: inv_nib};
                rx_st_reg <= pcsd_pkg::RX_IDLE;
              end
            end
            default: begin
              if (dgrp == pcsd_pkg::CG_T) begin
                o_rx <= '{dv: 1'b0, er: 1'b0, rxd: pcsd_pkg::NIB_ZERO};
                rx_st_reg <= pcsd_pkg::RX_IDLE;
              end else if (dgrp == pcsd_pkg::CG_IDLE && prev_idle_reg) begin
                o_rx <= '{dv: 1'b0, er: 1'b0, rxd: pcsd_pkg::NIB_ZERO};
                rx_st_reg <= pcsd_pkg::RX_IDLE;
              end else if (dat_hit) begin
                o_rx <= '{dv: 1'b1, er: 1'b0, rxd: dat_nib};
              end else begin
                // Halt, stray control groups and unused groups are errors.
                o_rx <= '{dv: 1'b1, er: 1'b1, rxd: inv_nib};
              end
            end
          endcase
        end
      end
    end
  end

  // Synchronization status straight from a flip-flop.
  always_ff @(posedge i_clk_rec) begin
    if (!rec_rst_n) begin
      o_sync <= 1'b0;
    end else begin
      o_sync <= lock_reg;
    end
  end

  a_lock_after_run: assert property (@(posedge i_clk_rec) disable iff (!rec_rst_n)
    $rose(lock_reg) |-> $past(run_reg) == 5'h0F && $past(grp_stb_reg))
    else $error("lock taken without sixteen idles");
  a_hold_start: assert property (@(posedge i_clk_rec) disable iff (!rec_rst_n)
    $rose(lock_reg) |-> tmr_reg == $past(tmr_load))
    else $error("hold timer not loaded at lock");
  a_hold_drop: assert property (@(posedge i_clk_rec) disable iff (!rec_rst_n)
    lock_reg && !cfg.hold_dis && tmr_reg == 18'h00001 && !reload |=> !lock_reg)
    else $error("lock kept after timer expiry");
  a_rx_silent: assert property (@(posedge i_clk_rec) disable iff (!rec_rst_n)
    hist_stb_reg && !sync_ok |=> !o_rx.dv && !o_rx.er)
    else $error("output presented while unsynchronized");
  a_inv_nibble: assert property (@(posedge i_clk_rec) disable iff (!rec_rst_n)
    hist_stb_reg && sync_ok && !cfg.byp_dec && rx_st_reg == pcsd_pkg::RX_DATA && !dat_hit
    && dgrp != pcsd_pkg::CG_T && dgrp != pcsd_pkg::CG_IDLE
    |=> o_rx.er && o_rx.rxd == (cfg.inv_sel ? 4'h5 : 4'h6))
    else $error("invalid group decoded wrongly");
endmodule : pcsd_top
`default_nettype wire

// >>> verif/pcsd_line_model.sv
// Line-side transmitter model: scrambles queued code-groups and NRZI-codes them bit by bit.
// Assumes the bench pushes groups into q; an empty queue sends idle groups continuously.
`default_nettype none
module pcsd_line_model (
  input wire logic i_clk,    // Recovered link clock.
  input wire logic i_rst_n,  // Synchronous reset, active low.
  input wire logic i_scr,    // Scramble the stream when high.
  input wire logic i_nrzi,   // NRZI-code the stream when high.
  output logic o_bit         // Serial line bit.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] q[$];     // Groups waiting to go out.
  logic [4:0] sh;       // Group being shifted out, first bit in bit 4.
  logic [2:0] cnt = 3'h0;  // Bit position within the group.
  logic [10:0] lfsr;    // Scrambling sequence generator.
  logic lvl;            // Current NRZI line level.
  logic key;            // Sequence bit for this cycle.
  logic nb;             // NRZ bit for this cycle.
  // One bit per link edge; a new group is fetched at each group boundary.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt = 3'h0;
      lfsr = 11'h7FF;
      lvl = 1'b0;
      o_bit <= 1'b0;
    end else begin
      if (cnt == 3'h0) begin
        if (q.size() > 0) sh = q.pop_front();
        else sh = 5'h1F;
      end
      key = lfsr[10] ^ lfsr[8];
      nb = sh[4] ^ (i_scr & key);
      lfsr = {lfsr[9:0], key};
      sh = {sh[3:0], 1'b0};
      cnt = (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      lvl = lvl ^ nb;
      o_bit <= i_nrzi ? lvl : nb;
    end
  end
endmodule : pcsd_line_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the codec: transmit encoding, lock, hold timer and receive decoding.
// Assumes the line model file is compiled first and both clocks run free.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;  // System clock.
  logic clk_rec = 1'b0;  // Link clock.
  logic rst_n = 1'b0;  // Reset, active low.
  pcsd_pkg::pcsd_cfg_t cfg = '0;  // Configuration levels.
  logic tx_en = 1'b0, tx_er = 1'b0, scr = 1'b1, nrzi = 1'b1, rx_bit;
  logic [3:0] txd = 4'h0;  // Transmit nibble.
  logic [4:0] tx_group;  // Group from the encoder.
  pcsd_pkg::pcsd_rx_t rx;  // Receive nibble interface.
  logic rx_stb, sync, sync_q;  // Strobe, lock and its delayed copy.
  logic [5:0] rxq[$], e[$];  // Seen and expected frame nibbles.
  int err_total = 0, samples_checked = 0, drops = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  always #24 clk_rec = ~clk_rec;
  pcsd_top #(.HOLD_CYCLES(400), .LONG_CYCLES(800)) u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_clk_rec(clk_rec), .i_cfg(cfg), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd),
    .i_rx_bit(rx_bit), .o_tx_group(tx_group), .o_rx(rx), .o_rx_stb(rx_stb), .o_sync(sync));
  pcsd_line_model u_line (.i_clk(clk_rec), .i_rst_n(rst_n), .i_scr(scr), .i_nrzi(nrzi),
    .o_bit(rx_bit));
  // Collects frame nibbles and counts every loss of lock.
  always @(posedge clk_rec) begin
    sync_q <= sync;
    if (sync_q === 1'b1 && sync === 1'b0) drops++;
    if (rx_stb === 1'b1 && rx.dv === 1'b1) rxq.push_back(rx);
  end
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic groups(input int n);
    repeat (5 * n) @(posedge clk_rec);
  endtask : groups
  // Waits until the line model has fetched everything queued, or 8000 link cycles pass.
  task automatic drain();
    int k;
    k = 0;
    while (u_line.q.size() != 0 && k < 8000) begin
      @(posedge clk_rec);
      k++;
    end
  endtask : drain
  task automatic send_data(input int n);
    for (int k = 0; k < n; k++) u_line.q.push_back(pcsd_pkg::DATA_CG[k % 16]);
    drain();
    groups(2);
  endtask : send_data
  task automatic put_cfg(input pcsd_pkg::pcsd_cfg_t c);
    @(posedge clk_sys);
    cfg <= c;
    groups(3);
  endtask : put_cfg
  // Drives one transmit cycle and checks the group caused by the previous cycle.
  task automatic tx_step(input logic en, input logic er, input logic [3:0] d,
      input logic [4:0] x);
    @(posedge clk_sys);
    tx_en <= en;
    tx_er <= er;
    txd <= d;
    #1 chk(tx_group, x);
  endtask : tx_step
  // Frame with all sixteen nibbles; odd ones errored when asked.
  task automatic t_tx(input logic erodd);
    logic [4:0] x;
    tx_step(1'b1, 1'b1, 4'h5, pcsd_pkg::CG_IDLE);
    tx_step(1'b1, 1'b1, 4'h5, pcsd_pkg::CG_J);
    x = pcsd_pkg::CG_K;
    for (int n = 0; n < 16; n++) begin
      tx_step(1'b1, erodd & n[0], n[3:0], x);
      x = (erodd & n[0]) ? pcsd_pkg::CG_HALT : pcsd_pkg::DATA_CG[n];
    end
    tx_step(1'b0, 1'b1, 4'h0, x);
    tx_step(1'b0, 1'b0, 4'h0, pcsd_pkg::CG_T);
    tx_step(1'b0, 1'b0, 4'h0, pcsd_pkg::CG_R);
    tx_step(1'b0, 1'b0, 4'h0, pcsd_pkg::CG_IDLE);
  endtask : t_tx
  // Early lock must not happen; lock must follow the idle run.
  task automatic t_lock();
    int k;
    groups(12);
    #1 chk(sync, 1'b0);
    k = 0;
    while (sync !== 1'b1 && k < 200) begin
      @(posedge clk_rec);
      #1 k++;
    end
    chk(sync, 1'b1);
  endtask : t_lock
  // Idles keep lock; data alone loses it; long and disabled timeouts hold it.
  task automatic t_hold();
    pcsd_pkg::pcsd_cfg_t c;
    int d0;
    d0 = drops;
    groups(150);
    chk(drops - d0, 8'h0);
    send_data(100);
    chk(drops - d0, 8'h1);
    @(posedge rx_stb);
    #1 chk(rx, 6'h00);
    c = '0;
    c.long_hold = 1'b1;
    put_cfg(c);
    t_lock();
    send_data(120);
    chk(drops - d0, 8'h1);
    c.hold_dis = 1'b1;
    put_cfg(c);
    send_data(200);
    chk(drops - d0, 8'h1);
    put_cfg('0);
  endtask : t_hold
  // Received frame with every data, invalid and misplaced control group.
  task automatic t_rx(input logic inv);
    logic [4:0] v[15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10,
      5'h19, 5'h1F, 5'h04, 5'h07, 5'h18, 5'h11};
    groups(4);
    rxq.delete();
    e = '{6'h25, 6'h25};
    u_line.q.push_back(pcsd_pkg::CG_J);
    u_line.q.push_back(pcsd_pkg::CG_K);
    for (int n = 0; n < 16; n++) begin
      u_line.q.push_back(pcsd_pkg::DATA_CG[n]);
      e.push_back({2'b10, n[3:0]});
    end
    foreach (v[i]) begin
      u_line.q.push_back(v[i]);
      e.push_back(inv ? 6'h35 : 6'h36);
    end
    u_line.q.push_back(pcsd_pkg::CG_T);
    u_line.q.push_back(pcsd_pkg::CG_R);
    drain();
    groups(8);
    chk(rxq.size(), 8'd33);
    foreach (e[i]) if (i < rxq.size()) chk(rxq[i], e[i]);
    chk(rx, 6'h00);
  endtask : t_rx
  // Decoder bypass hands raw aligned groups over, bit 4 riding on the error line.
  task automatic t_byp();
    logic [4:0] g[3] = '{5'h15, 5'h00, 5'h04};
    int k;
    rxq.delete();
    foreach (g[i]) u_line.q.push_back(g[i]);
    drain();
    groups(6);
    k = 0;
    while (k < rxq.size() && rxq[k] === 6'h3F) k++;
    foreach (g[i]) chk(rxq[k + i], {1'b1, g[i]});
  endtask : t_byp
  // Main sequence: reset, then every scenario in turn.
  initial begin
    pcsd_pkg::pcsd_cfg_t c;
    repeat (10) @(posedge clk_rec);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_tx(1'b0);
    t_tx(1'b1);
    t_lock();
    t_rx(1'b0);
    c = '0;
    c.inv_sel = 1'b1;
    put_cfg(c);
    t_rx(1'b1);
    t_hold();
    c = '0;
    c.byp_nrzi = 1'b1;
    c.byp_descr = 1'b1;
    put_cfg(c);
    @(posedge clk_rec);
    scr <= 1'b0;
    nrzi <= 1'b0;
    t_rx(1'b0);
    c.byp_dec = 1'b1;
    put_cfg(c);
    t_byp();
    summarize();
  end
endmodule : testbench
`default_nettype wire
